// file: logic/asq_sample_config.sv
// top: apb register bank for sequencers 1 and 2 plus their step engines
// ----------------------------------------
// ----------------------------------------
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module asq_sample_config import asq_pkg::*; #(
	parameter int CONV_CNT = CONV_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic [1:0] conv_valid,
	output logic [5:0] conv_input,
	output logic [1:0] conv_diff,
	output logic [1:0] conv_temp
);
	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic [3:0] reg_hit(input logic [11:0] a);
		case (a)
			SEQ1_INPUT_SELECT_OFF: reg_hit = 4'h1;
			SEQ1_STEP_CONTROL_OFF: reg_hit = 4'h2;
			SEQ2_INPUT_SELECT_OFF: reg_hit = 4'h3;
			SEQ2_STEP_CONTROL_OFF: reg_hit = 4'h4;
			SEQ_RUN_CTRL_OFF: reg_hit = 4'h5;
			SEQ_STATUS_OFF: reg_hit = 4'h6;
			IRQ_STATUS_OFF: reg_hit = 4'h7;
			IRQ_ENABLE_OFF: reg_hit = 4'h8;
			IRQ_CLEAR_OFF: reg_hit = 4'h9;
			default: reg_hit = 4'h0;
		endcase
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] sel_r [2], sel_nxt [2];
	logic [15:0] ctl_r [2], ctl_nxt [2];
	logic [1:0] ist_r, ist_nxt;
	logic [1:0] ien_r, ien_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic irq_r, irq_nxt;
	logic [1:0] start_r, start_nxt;
	logic [1:0] cv_r, cv_nxt, cd_r, cd_nxt, ct_r, ct_nxt;
	logic [5:0] ci_r, ci_nxt;
	logic [3:0] hit;
	logic setup, wr_acc;
	logic [1:0] busy, cvw, cdw, ctw, sirq;
	logic [2:0] ciw [2];

	assign hit = reg_hit(paddr);
	// answer one cycle after setup; access ends at the edge where pready is high
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;

	always_comb begin
		for (int s = 0; s < 2; s++) begin
			sel_nxt[s] = sel_r[s];
			ctl_nxt[s] = ctl_r[s];
		end
		ien_nxt = ien_r;
		start_nxt = 2'h0;
		if (wr_acc) begin
			case (hit)
				4'h1: sel_nxt[0] = pwdata[15:0] & SEL_WRITE_MASK;
				4'h2: ctl_nxt[0] = pwdata[15:0] & CTL_WRITE_MASK;
				4'h3: sel_nxt[1] = pwdata[15:0] & SEL_WRITE_MASK;
				4'h4: ctl_nxt[1] = pwdata[15:0] & CTL_WRITE_MASK;
				4'h5: start_nxt = pwdata[1:0] & ~busy;
				4'h8: ien_nxt = pwdata[1:0];
				default: begin
				end
			endcase
		end
	end

	// sticky status; a completion in the clearing cycle wins
	always_comb begin
		ist_nxt = ist_r;
		if (wr_acc && hit == 4'h9) begin
			ist_nxt = ist_nxt & ~pwdata[1:0];
		end
		ist_nxt = ist_nxt | sirq;
		irq_nxt = |(ist_nxt & ien_nxt);
	end

	always_comb begin
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		if (setup) begin
			pready_nxt = 1'b1;
			pslverr_nxt = (hit == 4'h0);
			case (hit)
				4'h1: prdata_nxt = {16'h0000, sel_r[0]};
				4'h2: prdata_nxt = {16'h0000, ctl_r[0]};
				4'h3: prdata_nxt = {16'h0000, sel_r[1]};
				4'h4: prdata_nxt = {16'h0000, ctl_r[1]};
				4'h6: prdata_nxt = {30'h0, busy};
				4'h7: prdata_nxt = {30'h0, ist_r};
				4'h8: prdata_nxt = {30'h0, ien_r};
				default: prdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_comb begin
		cv_nxt = cvw;
		cd_nxt = cdw;
		ct_nxt = ctw;
		ci_nxt = {ciw[1], ciw[0]};
	end

	// ----------------------------------------
	// engines
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_seq
			asq_seq_engine #(.CONV_CNT(CONV_CNT)) u_eng (
				.pclk(pclk),
				.presetn(presetn),
				.start(start_r[g]),
				.sel_cfg(sel_r[g]),
				.ctl_cfg(ctl_r[g]),
				.busy(busy[g]),
				.conv_valid(cvw[g]),
				.conv_input(ciw[g]),
				.conv_diff(cdw[g]),
				.conv_temp(ctw[g]),
				.step_irq(sirq[g]),
				.seq_done()
			);
		end
	endgenerate

	// ----------------------------------------
	// flops
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int s = 0; s < 2; s++) begin
				sel_r[s] <= SEL_RESET;
				ctl_r[s] <= CTL_RESET;
			end
			ist_r <= IRQ_RESET;
			ien_r <= IRQ_RESET;
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r <= 1'b0;
			start_r <= 2'h0;
			cv_r <= 2'h0;
			cd_r <= 2'h0;
			ct_r <= 2'h0;
			ci_r <= 6'h00;
		end else begin
			for (int s = 0; s < 2; s++) begin
				sel_r[s] <= sel_nxt[s];
				ctl_r[s] <= ctl_nxt[s];
			end
			ist_r <= ist_nxt;
			ien_r <= ien_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r <= irq_nxt;
			start_r <= start_nxt;
			cv_r <= cv_nxt;
			cd_r <= cd_nxt;
			ct_r <= ct_nxt;
			ci_r <= ci_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign conv_valid = cv_r;
	assign conv_input = ci_r;
	assign conv_diff = cd_r;
	assign conv_temp = ct_r;
endmodule

// file: pkg/asq_pkg.sv
// package: register map, field layout and timing for the sequencer 1/2 sample configuration block
package asq_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] SEQ1_INPUT_SELECT_OFF = 12'h060;
	localparam logic [11:0] SEQ1_STEP_CONTROL_OFF = 12'h064;
	localparam logic [11:0] SEQ2_INPUT_SELECT_OFF = 12'h080;
	localparam logic [11:0] SEQ2_STEP_CONTROL_OFF = 12'h084;
	localparam logic [11:0] SEQ_RUN_CTRL_OFF = 12'h0c0;
	localparam logic [11:0] SEQ_STATUS_OFF = 12'h0c4;
	localparam logic [11:0] IRQ_STATUS_OFF = 12'h0c8;
	localparam logic [11:0] IRQ_ENABLE_OFF = 12'h0cc;
	localparam logic [11:0] IRQ_CLEAR_OFF = 12'h0d0;
	// ----------------------------------------
	// field layout
	// ----------------------------------------
	localparam int STEPS = 4;
	localparam int SEL_W = 3;
	localparam int SEL_PITCH = 4;
	localparam int CTL_PITCH = 4;
	localparam int CTL_DIFF_POS = 0;
	localparam int CTL_LAST_POS = 1;
	localparam int CTL_IRQ_POS = 2;
	localparam int CTL_TEMP_POS = 3;
	localparam logic [15:0] SEL_WRITE_MASK = 16'h7777;
	localparam logic [15:0] CTL_WRITE_MASK = 16'hffff;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] SEL_RESET = 16'h0000;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [1:0] IRQ_RESET = 2'h0;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_TIME_NS = 1000;
	localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;

	typedef enum logic [1:0] {
		ASQ_IDLE = 2'b00,
		ASQ_CONV = 2'b01,
		ASQ_NEXT = 2'b10
	} asq_state_type;
endpackage

// file: logic/asq_seq_engine.sv
// step engine: walks one sequencer's steps, up to the one marked last or the fourth, using its configuration
`timescale 1ns/1ps
module asq_seq_engine import asq_pkg::*; #(
	parameter int CONV_CNT = CONV_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic [15:0] sel_cfg,
	input wire logic [15:0] ctl_cfg,
	output logic busy,
	output logic conv_valid,
	output logic [2:0] conv_input,
	output logic conv_diff,
	output logic conv_temp,
	output logic step_irq,
	output logic seq_done
);
	asq_state_type state_r, state_nxt;
	logic [1:0] step_r, step_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [3:0] ctl_now;

	assign ctl_now = ctl_cfg[step_r*CTL_PITCH +: CTL_PITCH];
	assign busy = (state_r != ASQ_IDLE);
	assign conv_input = sel_cfg[step_r*SEL_PITCH +: SEL_W];
	assign conv_diff = ctl_now[CTL_DIFF_POS];
	assign conv_temp = ctl_now[CTL_TEMP_POS];
	assign conv_valid = (state_r == ASQ_CONV);

	always_comb begin
		state_nxt = state_r;
		step_nxt = step_r;
		cnt_nxt = cnt_r;
		step_irq = 1'b0;
		seq_done = 1'b0;
		case (state_r)
			ASQ_IDLE: begin
				if (start) begin
					state_nxt = ASQ_CONV;
					step_nxt = 2'h0;
					cnt_nxt = CNT_W'(CONV_CNT - 1);
				end
			end
			ASQ_CONV: begin
				if (cnt_r == '0) begin
					state_nxt = ASQ_NEXT;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ASQ_NEXT: begin
				step_irq = ctl_now[CTL_IRQ_POS];
				// no marked step: stop after the fourth so the engine cannot spin
				if (ctl_now[CTL_LAST_POS] || step_r == 2'h3) begin
					seq_done = 1'b1;
					state_nxt = ASQ_IDLE;
				end else begin
					step_nxt = step_r + 1'b1;
					cnt_nxt = CNT_W'(CONV_CNT - 1);
					state_nxt = ASQ_CONV;
				end
			end
			default: begin
				state_nxt = ASQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ASQ_IDLE;
			step_r <= 2'h0;
			cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			step_r <= step_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// file: tb/asq_sample_config_assertions.sv
// checker: apb timing, decode, reserved bits and step length
`timescale 1ns/1ps
module asq_sample_config_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] conv_valid
);
	// --------
	// properties
	// --------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence rd_s(logic [11:0] a);
		pready && !pwrite && paddr == a;
	endsequence
	a_setup_ready: assert property (setup_s |=> pready) else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
	a_err_decode: assert property (pready |-> pslverr == !(paddr inside {12'h060, 12'h064, 12'h080,
		12'h084, 12'h0c0, 12'h0c4, 12'h0c8, 12'h0cc, 12'h0d0})) else $error("bad decode");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
	a_sel_resv: assert property (rd_s(12'h060) or rd_s(12'h080) |-> (prdata & 32'hffff8888) == 32'h0)
		else $error("select reserved");
	a_ctl_resv: assert property (rd_s(12'h064) or rd_s(12'h084) |-> prdata[31:16] == 16'h0)
		else $error("control reserved");
	a_conv_hold: assert property ($rose(conv_valid[0]) |=> conv_valid[0]) else $error("step too short");
	a_seq2_hold: assert property ($rose(conv_valid[1]) |=> conv_valid[1]) else $error("seq2 step too short");
endmodule

bind asq_sample_config asq_sample_config_checker u_chk(.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .conv_valid(conv_valid));

// file: tb/tb_asq_sample_config.sv
// testbench: registers, decode, step engine and interrupt of the config block
`timescale 1ns/1ps
module tb_asq_sample_config import asq_pkg::*;;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, rerr;
	logic [11:0] paddr = 0, b;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic [1:0] conv_valid, conv_diff, conv_temp;
	logic [5:0] conv_input;
	int failures = 0, total_checks = 0, cyc = 0, s, k;
	always #25 pclk = ~pclk;
	// short steps keep the run brief
	asq_sample_config #(.CONV_CNT(2)) DUT(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .conv_valid(conv_valid), .conv_input(conv_input),
		.conv_diff(conv_diff), .conv_temp(conv_temp));
	// --------
	// tasks
	// --------
	task report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task ax(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		ax(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	// bounded wait on the step strobe of sequencer q (seq1 or seq2)
	task wv(input int q, input logic v);
		int n;
		n = 0;
		while (conv_valid[q] !== v && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk(32'(conv_valid[q]), 32'(v));
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (s = 0; s < 2; s++) begin
			b = s ? 12'h080 : 12'h060;
			rc(b, 32'h0);
			rc(b + 12'h4, 32'h0);
			ax(1'b1, b, 32'hffffffff);
			rc(b, 32'h7777);
			ax(1'b1, b + 12'h4, 32'hffffffff);
			rc(b + 12'h4, 32'hffff);
			for (k = 0; k < 16; k++) begin
				ax(1'b1, b, 32'h1 << k);
				rc(b, (32'h1 << k) & 32'h7777);
				ax(1'b1, b + 12'h4, 32'h1 << k);
				rc(b + 12'h4, 32'h1 << k);
			end
		end
		// step1 input 5 diff irq, step2 input 3 temp last, step3 never runs
		// seq2: only step4 marked last, with input 6, diff and irq enable
		ax(1'b1, 12'h060, 32'h00000735);
		ax(1'b1, 12'h064, 32'h000000a5);
		ax(1'b1, 12'h080, 32'h00006000);
		ax(1'b1, 12'h084, 32'h00007000);
		rc(12'h060, 32'h735);
		chk(32'(rerr), 32'h0);
		rc(12'h064, 32'ha5);
		rc(12'h080, 32'h6000);
		rc(12'h084, 32'h7000);
		ax(1'b1, 12'h070, 32'h5);
		rc(12'h070, 32'h0);
		chk(32'(rerr), 32'h1);
		ax(1'b1, 12'h0cc, 32'h1);
		ax(1'b1, 12'h0c0, 32'h1);
		wv(0, 1'b1);
		chk(32'({conv_input[2:0], conv_diff[0], conv_temp[0]}), 32'h16);
		wv(0, 1'b0);
		wv(0, 1'b1);
		chk(32'({conv_input[2:0], conv_diff[0], conv_temp[0]}), 32'h0d);
		wv(0, 1'b0);
		repeat (30) @(posedge pclk);
		chk(32'({conv_valid, irq}), 32'h1);
		ax(1'b1, 12'h0cc, 32'h0);
		rc(12'h0c8, 32'h1);
		chk(32'(irq), 32'h0);
		ax(1'b1, 12'h0cc, 32'h1);
		rc(12'h0c8, 32'h1);
		chk(32'(irq), 32'h1);
		ax(1'b1, 12'h0d0, 32'h1);
		rc(12'h0c8, 32'h0);
		chk(32'(irq), 32'h0);
		// seq2 walks all four steps, stops after the marked fourth
		ax(1'b1, 12'h0c0, 32'h2);
		rc(12'h0c4, 32'h2);
		for (k = 0; k < 3; k++) begin
			wv(1, 1'b1);
			wv(1, 1'b0);
		end
		wv(1, 1'b1);
		chk(32'({conv_input[5:3], conv_diff[1], conv_temp[1]}), 32'h1a);
		wv(1, 1'b0);
		rc(12'h0c4, 32'h0);
		rc(12'h0c8, 32'h2);
		chk(32'(irq), 32'h0);
		ax(1'b1, 12'h0cc, 32'h2);
		rc(12'h0cc, 32'h2);
		chk(32'(irq), 32'h1);
		// second reset mid-run: configuration and status back to zero
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rc(12'h080, 32'h0);
		rc(12'h084, 32'h0);
		rc(12'h0c8, 32'h0);
		chk(32'(irq), 32'h0);
		report_and_stop();
	end
endmodule
